// ---- verilog/afe_regs_defines.svh ----
/*
 * Sub-addresses, field positions and reset values for the sensor front
 * end command and register decode.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef AFE_REGS_DEFINES_SVH
`define AFE_REGS_DEFINES_SVH

// ----------------------------------------------------------------------
// Command and gain register sub-addresses
// ----------------------------------------------------------------------
`define SUB_SW_RESET   8'h01
`define SUB_GAIN       8'h06
`define SUB_SEL_CH1    8'h10
`define SUB_SEL_CH2    8'h12
`define SUB_SEL_CH3    8'h14
`define SUB_SEL_CH4    8'h15
`define SUB_SEL_CH5    8'h18
`define SUB_SEL_CH6    8'h1a
`define SUB_SEL_CH7    8'h1c
`define SUB_SEL_CH8    8'h1e

// ----------------------------------------------------------------------
// Offset register sub-addresses
// ----------------------------------------------------------------------
`define SUB_OFS_CH1    8'h20
`define SUB_OFS_CH2    8'h22
`define SUB_OFS_CH3    8'h24
`define SUB_OFS_CH4    8'h25
`define SUB_OFS_CH5    8'h28
`define SUB_OFS_CH6    8'h2a
`define SUB_OFS_CH7    8'h2c
`define SUB_OFS_CH8    8'h2e

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define OFS_SIGN_BIT   10
`define OFS_MAG_MSB    9
`define OFS_RESET      16'h0000
`define GAIN_RESET     3'h0
`define CH_RESET       3'h0
`define DAC_RESET      11'h000

`endif

// ---- verilog/afe_regs_pkg.sv ----
/*
 * Types for the front end register decode.
 * Assumes the defines header is on the include path.
 */
package afe_regs_pkg;

    // Decoded meaning of a sub-address
    typedef enum {
        SUB_NONE,
        SUB_RESET,
        SUB_SELECT,
        SUB_GAIN_REG,
        SUB_OFFSET_REG
    } sub_kind_t;

    // Access state: waiting for sub-address, then parameter bytes
    typedef enum {
        ST_IDLE,
        ST_SUB,
        ST_BYTE_HI,
        ST_BYTE_LO,
        ST_DONE
    } acc_state_t;

endpackage : afe_regs_pkg

// ---- verilog/afe_channel_offset_gain_regs.sv ----
/*
 * Command and register decode for an eight-channel sensor front end.
 * Assumes a serial protocol engine in front that delivers each received
 * byte as a one-cycle strobe, flags the start of a transfer and its stop,
 * and asks for read bytes by a one-cycle request, all synchronous to
 * sys_clk.
 * Reads follow the sub-address of the most recent access; a new start
 * keeps that context until a fresh sub-address byte arrives.
 * The analog side may sample the channel, gain and offset outputs at
 * any time, so each of them comes straight from a flip-flop.
 * Limitation: a sign bit with a zero magnitude is passed on as it
 * stands; the DAC is expected to treat it as zero offset.
 */
// Functional notes
// - Channel 1-8 select commands carry no data
// - Eight two-byte offset registers, read and write
// - Offset bit 10 is the polarity
// - Offset bits 9:0 are the magnitude
// - Codes 0x000 and 0x400 both mean zero
// - Three-bit code selects one of eight gains
// - Unknown sub-addresses leave state untouched
// - Gain in bits 2:0 at 0x06, resets 0
// - Only the selected channel offset drives DAC
`timescale 1ns/10ps
`include "afe_regs_defines.svh"

module afe_channel_offset_gain_regs
    import afe_regs_pkg::*;
#(
    parameter int NUM_CH = 8
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Byte stream from the serial engine
    input  wire logic        xfer_start,
    input  wire logic        xfer_stop,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        tx_req,
    output logic      [7:0]  tx_byte,
    // Analog controls
    output logic      [2:0]  chan_sel,
    output logic      [2:0]  gain_code,
    output logic             ofs_negative,
    output logic      [9:0]  ofs_magnitude
);

    // ------------------------------------------------------------------
    // Sub-address decode
    // ------------------------------------------------------------------

    // Kind of access named by a sub-address
    function automatic sub_kind_t decode_kind(input logic [7:0] sa);
        case (sa)
            `SUB_SW_RESET: decode_kind = SUB_RESET;
            `SUB_GAIN:     decode_kind = SUB_GAIN_REG;
            `SUB_SEL_CH1, `SUB_SEL_CH2, `SUB_SEL_CH3, `SUB_SEL_CH4,
            `SUB_SEL_CH5, `SUB_SEL_CH6, `SUB_SEL_CH7,
            `SUB_SEL_CH8:  decode_kind = SUB_SELECT;
            `SUB_OFS_CH1, `SUB_OFS_CH2, `SUB_OFS_CH3, `SUB_OFS_CH4,
            `SUB_OFS_CH5, `SUB_OFS_CH6, `SUB_OFS_CH7,
            `SUB_OFS_CH8:  decode_kind = SUB_OFFSET_REG;
            default:       decode_kind = SUB_NONE;
        endcase
    endfunction : decode_kind

    // Channel index (0 = channel 1) named by a sub-address
    function automatic logic [2:0] decode_chan(input logic [7:0] sa);
        case (sa)
            `SUB_SEL_CH2, `SUB_OFS_CH2: decode_chan = 3'h1;
            `SUB_SEL_CH3, `SUB_OFS_CH3: decode_chan = 3'h2;
            `SUB_SEL_CH4, `SUB_OFS_CH4: decode_chan = 3'h3;
            `SUB_SEL_CH5, `SUB_OFS_CH5: decode_chan = 3'h4;
            `SUB_SEL_CH6, `SUB_OFS_CH6: decode_chan = 3'h5;
            `SUB_SEL_CH7, `SUB_OFS_CH7: decode_chan = 3'h6;
            `SUB_SEL_CH8, `SUB_OFS_CH8: decode_chan = 3'h7;
            default:                    decode_chan = 3'h0;
        endcase
    endfunction : decode_chan

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    acc_state_t  state_r,    state_nxt;     // Access sequence
    sub_kind_t   kind_r,     kind_nxt;      // Kind of current access
    logic [2:0]  acc_ch_r,   acc_ch_nxt;    // Channel of current access
    logic [7:0]  hi_byte_r,  hi_byte_nxt;   // Offset high byte held
    logic        rd_hi_r,    rd_hi_nxt;     // Next read byte is the high
    logic [2:0]  chan_r,     chan_nxt;      // Selected channel
    logic [2:0]  gain_r,     gain_nxt;      // Gain code
    logic [7:0]  tx_r,       tx_nxt;        // Read data to the engine
    logic [15:0] ofs_r   [NUM_CH];          // Offset registers
    logic [15:0] ofs_nxt [NUM_CH];
    logic [10:0] dac_r,      dac_nxt;       // Offset code at the DAC

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // Byte sequencing and register writes; an offset write commits only when
    // both parameter bytes arrived, so a cut-off access never leaves
    // half a value in a register.
    // Framing is applied last so that a start or stop always wins over
    // the next state the byte sequence asked for in the same cycle.
    always_comb begin
        sub_kind_t k;
        // Decode the current byte once; only the sub slot acts on it
        k           = decode_kind(rx_byte);
        // Everything holds unless a branch below says otherwise
        state_nxt   = state_r;
        kind_nxt    = kind_r;
        acc_ch_nxt  = acc_ch_r;
        hi_byte_nxt = hi_byte_r;
        chan_nxt    = chan_r;
        gain_nxt    = gain_r;
        for (int i = 0; i < NUM_CH; i++) begin
            ofs_nxt[i] = ofs_r[i];
        end
        case (state_r)
            ST_IDLE: begin
                // Wait for a transfer to open; bytes without a start
                // belong to nobody and are dropped
            end
            ST_SUB: begin
                // First byte after a start names the access
                if (rx_valid) begin
                    kind_nxt   = k;
                    acc_ch_nxt = decode_chan(rx_byte);
                    case (k)
                        SUB_SELECT: begin
                            // Select takes effect at once, no data
                            chan_nxt  = decode_chan(rx_byte);
                            state_nxt = ST_DONE;
                        end
                        SUB_RESET: begin
                            // Channel, gain and offsets back to power-up values in one step
                            chan_nxt = `CH_RESET;
                            gain_nxt = `GAIN_RESET;
                            for (int i = 0; i < NUM_CH; i++) begin
                                ofs_nxt[i] = `OFS_RESET;
                            end
                            state_nxt = ST_DONE;
                        end
                        // Gain has a single parameter byte
                        SUB_GAIN_REG:   state_nxt = ST_BYTE_LO;
                        // Offsets take a high byte, then a low one
                        SUB_OFFSET_REG: state_nxt = ST_BYTE_HI;
                        // Unlisted addresses swallow the rest quietly
                        default:        state_nxt = ST_DONE;
                    endcase
                end
            end
            ST_BYTE_HI: begin
                // Offset high byte first, held until the low byte
                if (rx_valid) begin
                    hi_byte_nxt = rx_byte;
                    state_nxt   = ST_BYTE_LO;
                end
            end
            ST_BYTE_LO: begin
                // Last parameter byte commits the whole value; the
                // gain keeps only its three code bits
                if (rx_valid) begin
                    if (kind_r == SUB_GAIN_REG) begin
                        gain_nxt = rx_byte[2:0];
                    end else begin
                        ofs_nxt[acc_ch_r] = {hi_byte_r, rx_byte};
                    end
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                // Extra bytes are ignored until stop or a new start, so a master that
                // sends too much cannot spill into another register
            end
            // Unused encodings fall back to idle
            default: state_nxt = ST_IDLE;
        endcase
        // Framing overrides the sequence; start comes last so that
        // it wins a tie with stop
        if (xfer_stop) begin
            state_nxt = ST_IDLE;
        end
        if (xfer_start) begin
            state_nxt = ST_SUB;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------

    // Read bytes: offsets high byte then low, gain as one byte; a third
    // request on an offset repeats the low byte, and reads of commands
    // or unknown addresses return zero.
    always_comb begin
        tx_nxt    = tx_r;
        rd_hi_nxt = rd_hi_r;
        // A fresh sub-address restarts an offset read at its high byte
        if ((state_r == ST_SUB) && rx_valid) begin
            rd_hi_nxt = 1'b1;
        end
        if (tx_req) begin
            case (kind_r)
                SUB_GAIN_REG: tx_nxt = {5'h00, gain_r};
                SUB_OFFSET_REG: begin
                    tx_nxt = rd_hi_r ? ofs_r[acc_ch_r][15:8]
                                     : ofs_r[acc_ch_r][7:0];
                    rd_hi_nxt = 1'b0;
                end
                default: tx_nxt = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Applied offset
    // ------------------------------------------------------------------

    // Offset code applied to the DAC; taken from the next values so it
    // moves in the same cycle as a select or a write of that channel
    always_comb begin
        dac_nxt = ofs_nxt[chan_nxt][`OFS_SIGN_BIT:0];
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    // Control registers; a plain load of the next values, every
    // decision lives in the logic above
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= ST_IDLE;
            kind_r    <= SUB_NONE;
            acc_ch_r  <= 3'h0;
            hi_byte_r <= 8'h00;
            chan_r    <= `CH_RESET;
            gain_r    <= `GAIN_RESET;
        end else begin
            state_r   <= state_nxt;
            kind_r    <= kind_nxt;
            acc_ch_r  <= acc_ch_nxt;
            hi_byte_r <= hi_byte_nxt;
            chan_r    <= chan_nxt;
            gain_r    <= gain_nxt;
        end
    end

    // Read data registers; tx_byte stands until the next request
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_hi_r <= 1'b1;
            tx_r    <= 8'h00;
        end else begin
            rd_hi_r <= rd_hi_nxt;
            tx_r    <= tx_nxt;
        end
    end

    // Applied offset register, cleared together with the bank
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dac_r <= `DAC_RESET;
        end else begin
            dac_r <= dac_nxt;
        end
    end

    // Offset bank, one register per channel; kept in its own loop so
    // each channel's storage stays a separate, uniform slice
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_ofs
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    ofs_r[g] <= `OFS_RESET;
                end else begin
                    ofs_r[g] <= ofs_nxt[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Only the selected channel's code reaches the DAC; sign 1 with a
    // zero magnitude is still zero offset, the analog side sees mag 0.
    // Every output is a flip-flop, so the analog controls never glitch
    // while a select and a write land in the same transfer.
    assign chan_sel      = chan_r;
    assign gain_code     = gain_r;
    assign ofs_negative  = dac_r[`OFS_SIGN_BIT];
    assign ofs_magnitude = dac_r[`OFS_MAG_MSB:0];
    assign tx_byte       = tx_r;

endmodule : afe_channel_offset_gain_regs

// ---- sim/afe_regs_checker.sv ----
/* Concurrent checks on the register decode ports.
   Assumes one clock domain and a bind to the decode module. */
`timescale 1ns/10ps
module afe_regs_checker #(
    parameter int NUM_CH = 8
) (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       reset_n,
    // Byte stream
    input wire logic       xfer_start,
    input wire logic       xfer_stop,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic       tx_req,
    input wire logic [7:0] tx_byte,
    // Analog controls
    input wire logic [2:0] chan_sel,
    input wire logic [2:0] gain_code,
    input wire logic       ofs_negative,
    input wire logic [9:0] ofs_magnitude
);
    // ------------------------------------------------
    // Helper state
    // ------------------------------------------------
    localparam logic [7:0] SEL [8] = '{8'h10, 8'h12, 8'h14, 8'h15,
                                       8'h18, 8'h1a, 8'h1c, 8'h1e};
    localparam logic [7:0] OFS [8] = '{8'h20, 8'h22, 8'h24, 8'h25,
                                       8'h28, 8'h2a, 8'h2c, 8'h2e};
    logic       wait_r;   // Next byte is a sub-address
    logic [7:0] last_r;   // Sub-address that reads refer to
    logic       hit;      // Sub-address byte this cycle
    logic [3:0] sel;      // Select command flag and channel
    // Only listed sub-addresses have any function
    function automatic logic known(input logic [7:0] b);
        known = (b == 8'h01) || (b == 8'h06);
        for (int i = 0; i < 8; i++) begin
            known = known || (b == SEL[i]) || (b == OFS[i]);
        end
    endfunction : known
    // Decode the select commands of the current byte
    always_comb begin
        hit = wait_r && rx_valid;
        sel = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (rx_byte == SEL[i]) begin
                sel = {1'b1, 3'(i)};
            end
        end
    end
    // Track the sub-address slot; stop ends it, start wins over stop
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_r <= 1'b0;
            last_r <= 8'h00;
        end else begin
            wait_r <= xfer_start || (wait_r && !rx_valid && !xfer_stop);
            last_r <= hit ? rx_byte : last_r;
        end
    end
    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_SEL_CMD: assert property (
        hit && sel[3] |=> chan_sel == $past(sel[2:0]))
        else $error("select command missed");
    AST_SEL_CAUSE: assert property (
        $changed(chan_sel) |-> $past(hit))
        else $error("channel changed without a command");
    AST_GAIN_WR: assert property (
        $changed(gain_code) |-> $past(rx_valid) &&
        (gain_code == $past(rx_byte[2:0]) || gain_code == 3'h0))
        else $error("gain changed to a wrong code");
    AST_OFS_CAUSE: assert property (
        $changed({ofs_negative, ofs_magnitude}) |-> $past(rx_valid))
        else $error("offset output moved on its own");
    AST_SRST: assert property (
        hit && rx_byte == 8'h01 |=> chan_sel == 3'h0 &&
        gain_code == 3'h0 && {ofs_negative, ofs_magnitude} == 11'h000)
        else $error("software reset left state");
    AST_RST_VAL: assert property (
        $rose(reset_n) |-> chan_sel == 3'h0 && gain_code == 3'h0 &&
        {ofs_negative, ofs_magnitude} == 11'h000)
        else $error("wrong value after reset");
    AST_UNKNOWN: assert property (
        hit && !known(rx_byte) |=> $stable(chan_sel) &&
        $stable(gain_code) && $stable({ofs_negative, ofs_magnitude}))
        else $error("unknown sub-address changed state");
    AST_TX_UNKNOWN: assert property (
        tx_req && !known(last_r) |=> tx_byte == 8'h00)
        else $error("unknown sub-address read not zero");
endmodule : afe_regs_checker

bind afe_channel_offset_gain_regs afe_regs_checker
    #(.NUM_CH(NUM_CH)) chk_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .xfer_start(xfer_start),
    .xfer_stop(xfer_stop), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_req(tx_req), .tx_byte(tx_byte), .chan_sel(chan_sel),
    .gain_code(gain_code), .ofs_negative(ofs_negative),
    .ofs_magnitude(ofs_magnitude));

// ---- sim/afe_host_model.sv ----
/* Bus master and serial engine seen as a byte stream.
   Assumes the bench calls one task at a time. */
`timescale 1ns/10ps
module afe_host_model (
    // Clock
    input wire logic       sys_clk,
    // Byte stream to the decode
    output logic           xfer_start,
    output logic           xfer_stop,
    output logic           rx_valid,
    output logic     [7:0] rx_byte,
    output logic           tx_req,
    // Read data
    input wire logic [7:0] tx_byte
);
    initial begin
        {xfer_start, xfer_stop, rx_valid, tx_req} = 4'h0;
        rx_byte = 8'h00;
    end
    // One-cycle start and stop pulses
    task automatic start_t;
        @(posedge sys_clk) xfer_start <= 1'b1;
        @(posedge sys_clk) xfer_start <= 1'b0;
    endtask : start_t
    task automatic stop_t;
        @(posedge sys_clk) xfer_stop <= 1'b1;
        @(posedge sys_clk) xfer_stop <= 1'b0;
    endtask : stop_t
    // One byte; the line shows garbage once released
    task automatic byte_t(input logic [7:0] b);
        @(posedge sys_clk) {rx_valid, rx_byte} <= {1'b1, b};
        @(posedge sys_clk) {rx_valid, rx_byte} <= {1'b0, ~b};
    endtask : byte_t
    // Ask for a read byte; data is there the cycle after
    task automatic rd_t(output logic [7:0] b);
        @(posedge sys_clk) tx_req <= 1'b1;
        @(posedge sys_clk) tx_req <= 1'b0;
        #1 b = tx_byte;
    endtask : rd_t
endmodule : afe_host_model

// ---- sim/afe_channel_offset_gain_regs_test.sv ----
/* Self-checking bench for the register decode.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/10ps
module afe_channel_offset_gain_regs_test;
    logic        sys_clk, reset_n, xfer_start, xfer_stop;
    logic        rx_valid, tx_req, ofs_negative;
    logic [7:0]  rx_byte, tx_byte, hi, lo;
    logic [2:0]  chan_sel, gain_code;
    logic [9:0]  ofs_magnitude;
    logic [15:0] ofs_m [8];  // Expected offset per channel
    logic [15:0] v;          // Read-back value
    int          bad_count, n_tests;
    localparam logic [7:0] SEL [8] = '{8'h10, 8'h12, 8'h14, 8'h15,
                                       8'h18, 8'h1a, 8'h1c, 8'h1e};
    localparam logic [7:0] OFS [8] = '{8'h20, 8'h22, 8'h24, 8'h25,
                                       8'h28, 8'h2a, 8'h2c, 8'h2e};
    afe_channel_offset_gain_regs #(.NUM_CH(8)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .xfer_start(xfer_start),
        .xfer_stop(xfer_stop), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_req(tx_req), .tx_byte(tx_byte), .chan_sel(chan_sel),
        .gain_code(gain_code), .ofs_negative(ofs_negative),
        .ofs_magnitude(ofs_magnitude));
    afe_host_model host_u (
        .sys_clk(sys_clk), .xfer_start(xfer_start),
        .xfer_stop(xfer_stop), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_req(tx_req), .tx_byte(tx_byte));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Compare one value and count it
    task automatic chk(input logic [15:0] s, e, input string m);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %0t %s: %h not %h", $time, m, s, e);
        end
    endtask : chk
    // Offset outputs expected from a stored register value
    function automatic logic [15:0] dac(input logic [15:0] r);
        return {5'h00, r[10:0]};
    endfunction : dac
    // Command with no parameter bytes
    task automatic cmd(input logic [7:0] s);
        host_u.start_t();
        host_u.byte_t(s);
        host_u.stop_t();
    endtask : cmd
    // Two-byte write, high byte first
    task automatic wr16(input logic [7:0] s, input logic [15:0] d);
        host_u.start_t();
        host_u.byte_t(s);
        host_u.byte_t(d[15:8]);
        host_u.byte_t(d[7:0]);
        host_u.stop_t();
    endtask : wr16
    // Set read context, then fetch two bytes
    task automatic rd(input logic [7:0] s, output logic [15:0] d);
        cmd(s);
        host_u.start_t();
        host_u.rd_t(hi);
        host_u.rd_t(lo);
        host_u.stop_t();
        d = {hi, lo};
    endtask : rd
    // Channel, gain and offset outputs back at reset values
    task automatic chk_clear;
        chk({10'h0, chan_sel, gain_code}, 16'h0, "sel gain");
        chk({5'h0, ofs_negative, ofs_magnitude}, 16'h0, "dac");
    endtask : chk_clear
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    initial begin
        #(25 * 20000);
        bad_count++;
        wrap_up();
    end
    initial begin
        reset_n = 1'b0;
        bad_count = 0;
        n_tests = 0;
        void'($urandom(38));
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        chk_clear();
        for (int i = 0; i < 8; i++) begin
            rd(OFS[i], v);
            chk(v, 16'h0, "offset reset");
        end
        $display("test reset done");
        for (int g = 0; g < 8; g++) begin
            host_u.start_t();
            host_u.byte_t(8'h06);
            host_u.byte_t({5'($urandom), 3'(g)});
            host_u.stop_t();
            chk(16'(gain_code), 16'(g), "gain");
            rd(8'h06, v);
            chk(16'(v[15:8]), 16'(g), "gain read");
        end
        $display("test gain done");
        ofs_m = '{16'h03ff, 16'h07ff, 16'h0400, 16'h0000,
                  16'h0000, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            if (i > 3) ofs_m[i] = 16'($urandom) & 16'h07ff;
            wr16(OFS[i], ofs_m[i]);
        end
        for (int i = 7; i >= 0; i--) begin
            cmd(SEL[i]);
            chk(16'(chan_sel), 16'(i), "select");
            chk({5'h0, ofs_negative, ofs_magnitude}, dac(ofs_m[i]),
                "dac");
            rd(OFS[i], v);
            chk(v, ofs_m[i], "offset read");
        end
        $display("test offsets done");
        cmd(8'h13);
        wr16(8'h21, 16'h07ff);
        chk({10'h0, chan_sel, gain_code}, 16'h07, "unknown");
        chk({5'h0, ofs_negative, ofs_magnitude}, dac(ofs_m[0]),
            "unknown dac");
        rd(8'h21, v);
        chk(v, 16'h0, "unknown read");
        $display("test unknown done");
        cmd(8'h01);
        chk_clear();
        rd(OFS[7], v);
        chk(v, 16'h0, "soft reset offset");
        cmd(SEL[5]);
        wr16(OFS[5], 16'h0555);
        chk({5'h0, ofs_negative, ofs_magnitude}, 16'h0555, "pre");
        @(posedge sys_clk) reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        chk_clear();
        rd(OFS[5], v);
        chk(v, 16'h0, "reset offset");
        $display("test resets done");
        wrap_up();
    end
endmodule : afe_channel_offset_gain_regs_test
